/* bidio_pkg.sv */
package bidio_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry of the port block.
    localparam int BIDIO_MAX_LINES = 24;
    localparam int BIDIO_MIN_LINES = 16;
    localparam int BIDIO_NPORTS = 3;
    localparam int BIDIO_PORT_W = 8;
    localparam logic [23:0] BIDIO_ALL_LINES = 24'hFFFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the bus.
    localparam logic [7:0] BIDIO_OFS_A_DATA = 8'h00;
    localparam logic [7:0] BIDIO_OFS_A_DIR = 8'h04;
    localparam logic [7:0] BIDIO_OFS_B_DATA = 8'h08;
    localparam logic [7:0] BIDIO_OFS_B_DIR = 8'h0C;
    localparam logic [7:0] BIDIO_OFS_D_DATA = 8'h10;
    localparam logic [7:0] BIDIO_OFS_D_DIR = 8'h14;
    localparam logic [7:0] BIDIO_OFS_WAKE_EN = 8'h18;
    localparam logic [7:0] BIDIO_OFS_BITOP = 8'h1C;
    localparam logic [7:0] BIDIO_OFS_POWER = 8'h20;
    localparam logic [7:0] BIDIO_OFS_INFO = 8'h24;
    localparam logic [7:0] BIDIO_PORT_STRIDE = 8'h08;
    localparam logic [7:0] BIDIO_DIR_STEP = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int BIDIO_BITOP_IDX_LSB = 0;
    localparam int BIDIO_BITOP_VAL_BIT = 3;
    localparam int BIDIO_BITOP_TGT_LSB = 4;
    localparam logic [2:0] BIDIO_BITOP_TGT_LAST = 3'h5;
    localparam int BIDIO_PWR_DOWN_BIT = 0;
    localparam int BIDIO_PWR_WAKE_BIT = 1;
    localparam int BIDIO_INFO_ASW_BIT = 8;
    localparam int BIDIO_INFO_RCO_BIT = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] BIDIO_DATA_RESET = 8'hFF;
    localparam logic [7:0] BIDIO_DIR_RESET = 8'hFF;
    localparam logic [7:0] BIDIO_WAKE_RESET = 8'h00;

    // Port D bits 4..7: converter output, resistor, timing, capacitor pins.
    localparam logic [7:0] BIDIO_CONV_MASK = 8'hF0;

    function automatic logic [7:0] bidio_data_ofs(input int p);
        return 8'(BIDIO_OFS_A_DATA + BIDIO_PORT_STRIDE * p);
    endfunction

    function automatic logic [7:0] bidio_dir_ofs(input int p);
        return 8'(bidio_data_ofs(p) + BIDIO_DIR_STEP);
    endfunction

    function automatic logic [7:0] bidio_bit_modify(input logic [7:0] src,
                                                    input logic [2:0] idx,
                                                    input logic val);
        logic [7:0] res;
        res = src;
        res[idx] = val;
        return res;
    endfunction

endpackage

/* bidio_sync.sv */
`timescale 1ns/10ps
module bidio_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // bidio_sync

/* bidio_port_slice.sv */
`timescale 1ns/10ps
module bidio_port_slice
    import bidio_pkg::*;
#(
    parameter logic [7:0] PULLUP_MASK = 8'h00,
    parameter logic [7:0] SHARED_MASK = 8'h00
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic data_we_i,
    input wire logic dir_we_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] pin_level_i,
    output logic [7:0] data_o,
    output logic [7:0] dir_o,
    output logic [7:0] view_o,
    output logic [7:0] drive_o,
    output logic [7:0] oe_o,
    output logic [7:0] pullup_o
);

    logic [7:0] data_r;
    logic [7:0] dir_r;

    // The latch only changes on an explicit write.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_r <= BIDIO_DATA_RESET;
        end else if (data_we_i) begin
            data_r <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_r <= BIDIO_DIR_RESET;
        end else if (dir_we_i) begin
            dir_r <= wdata_i;
        end
    end

    assign data_o = data_r;
    assign dir_o = dir_r;
    // Inputs show the pin, outputs show the latch.
    assign view_o = (dir_r & pin_level_i) | (~dir_r & data_r);
    assign drive_o = data_r & ~SHARED_MASK;
    assign oe_o = ~dir_r & ~SHARED_MASK;
    assign pullup_o = dir_r & PULLUP_MASK & ~SHARED_MASK;

endmodule // bidio_port_slice

/* bidio_top.sv */
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - Direction bit one input, zero output.
// - Inputs unlatched, pin sampled at read.
// - Output latch holds until rewritten.
// - Output pins read back latch value.
// - Reset sets data and direction ones.
// - New output drives high without write.
// - Bit operations read, modify, write byte.
// - Port A falling edge wakes power-down.
// - Wake-up enabled per port A pin.
// - Fixed option adds weak input pull-up.
// - Port B becomes analog switch lines.
// - Port D upper pins join converter.
// - Sixteen to twenty-four lines, byte ports.
module bidio_top
    import bidio_pkg::*;
#(
    parameter int LINES = 24,
    parameter logic [23:0] PULLUP_OPT = 24'h000000,
    parameter bit ASW_OPT = 1'b0,
    parameter bit RCO_OPT = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [LINES-1:0] port_pin_i,
    output logic [LINES-1:0] port_pin_o,
    output logic [LINES-1:0] port_pin_oe_o,
    output logic [LINES-1:0] pullup_en_o,
    output logic [7:0] analog_switch_sel_o,
    output logic [3:0] converter_sel_o,
    output logic power_down_o,
    output logic wake_o
);

    localparam int PW = BIDIO_MAX_LINES;
    localparam int NP = BIDIO_NPORTS;
    localparam logic [23:0] LINE_MASK = BIDIO_ALL_LINES >> (PW - LINES);
    localparam logic [23:0] SHARED_MASK = {RCO_OPT ? BIDIO_CONV_MASK : 8'h00,
                                           ASW_OPT ? 8'hFF : 8'h00, 8'h00};

    ////////////////////////////////////////////////////////////////////////////
    // Variants come in steps of four lines; the converter needs all of port D.
    generate
        if (LINES < BIDIO_MIN_LINES || LINES > BIDIO_MAX_LINES || (LINES % 4) != 0)
        begin : g_bad_lines
            $error("bidio_top: unsupported number of port lines");
        end
        if (RCO_OPT && LINES != BIDIO_MAX_LINES) begin : g_bad_rco
            $error("bidio_top: converter option needs the full port D");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.
    logic [PW-1:0] pin_ext;
    logic [PW-1:0] pin_sync;

    always_comb begin
        pin_ext = '0;
        pin_ext[LINES-1:0] = port_pin_i;
    end

    bidio_sync #(
        .WIDTH(PW)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_ext),
        .sync_o(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port slices.
    logic [7:0] port_data [NP];
    logic [7:0] port_dir [NP];
    logic [7:0] port_view [NP];
    logic [7:0] port_drive [NP];
    logic [7:0] port_oe [NP];
    logic [7:0] port_pull [NP];
    logic [NP-1:0] data_we;
    logic [NP-1:0] dir_we;
    logic [7:0] port_wval;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            bidio_port_slice #(
                .PULLUP_MASK(PULLUP_OPT[8*gp +: 8] & LINE_MASK[8*gp +: 8]),
                .SHARED_MASK(SHARED_MASK[8*gp +: 8])
            ) u_slice (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .data_we_i(data_we[gp]),
                .dir_we_i(dir_we[gp]),
                .wdata_i(port_wval),
                .pin_level_i(pin_sync[8*gp +: 8]),
                .data_o(port_data[gp]),
                .dir_o(port_dir[gp]),
                .view_o(port_view[gp]),
                .drive_o(port_drive[gp]),
                .oe_o(port_oe[gp]),
                .pullup_o(port_pull[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.
    logic ack_r;
    logic [31:0] rdata_r;
    logic take;
    logic bus_wr;
    logic bitop_wr;
    logic halt_wr;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [2:0] bit_tgt;

    assign take = wb_cyc_i & wb_stb_i & ~ack_r;
    assign bus_wr = take & wb_we_i & wb_sel_i[0];
    assign bitop_wr = bus_wr && (wb_adr_i == BIDIO_OFS_BITOP);
    assign halt_wr = bus_wr && (wb_adr_i == BIDIO_OFS_POWER) && wb_dat_i[BIDIO_PWR_DOWN_BIT];
    assign bit_idx = wb_dat_i[BIDIO_BITOP_IDX_LSB +: 3];
    assign bit_val = wb_dat_i[BIDIO_BITOP_VAL_BIT];
    assign bit_tgt = wb_dat_i[BIDIO_BITOP_TGT_LSB +: 3];

    // A bit operation on a data register reads the whole port as software would see it, so an input
    // pin's present level lands in its latch; this mirrors the original hazard.
    always_comb begin
        data_we = '0;
        dir_we = '0;
        port_wval = wb_dat_i[7:0];
        for (int p = 0; p < NP; p++) begin
            if (bus_wr && wb_adr_i == bidio_data_ofs(p)) begin
                data_we[p] = 1'b1;
            end
            if (bus_wr && wb_adr_i == bidio_dir_ofs(p)) begin
                dir_we[p] = 1'b1;
            end
        end
        if (bitop_wr && bit_tgt <= BIDIO_BITOP_TGT_LAST) begin
            if (bit_tgt[0]) begin
                dir_we[bit_tgt[2:1]] = 1'b1;
                port_wval = bidio_bit_modify(port_dir[bit_tgt[2:1]], bit_idx, bit_val);
            end else begin
                data_we[bit_tgt[2:1]] = 1'b1;
                port_wval = bidio_bit_modify(port_view[bit_tgt[2:1]], bit_idx, bit_val);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up logic.
    logic [7:0] wake_en_r;
    logic [7:0] prev_a_r;
    logic [7:0] fall_a;
    logic wake_evt;
    logic power_down_r;
    logic wake_flag_r;
    logic wake_r;

    assign fall_a = prev_a_r & ~pin_sync[7:0] & wake_en_r;
    assign wake_evt = power_down_r & (|fall_a);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_en_r <= BIDIO_WAKE_RESET;
        end else if (bus_wr && wb_adr_i == BIDIO_OFS_WAKE_EN) begin
            wake_en_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_a_r <= '0;
        end else begin
            prev_a_r <= pin_sync[7:0];
        end
    end

    // A halt request in the wake cycle wins, since it was issued after the edge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_down_r <= 1'b0;
        end else if (halt_wr) begin
            power_down_r <= 1'b1;
        end else if (wake_evt) begin
            power_down_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_flag_r <= 1'b0;
        end else if (wake_evt) begin
            wake_flag_r <= 1'b1;
        end else if (bus_wr && wb_adr_i == BIDIO_OFS_POWER && wb_dat_i[BIDIO_PWR_WAKE_BIT]) begin
            wake_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge.
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        for (int p = 0; p < NP; p++) begin
            if (wb_adr_i == bidio_data_ofs(p)) begin
                rd_nxt[7:0] = port_view[p] & LINE_MASK[8*p +: 8];
            end
            if (wb_adr_i == bidio_dir_ofs(p)) begin
                rd_nxt[7:0] = port_dir[p] & LINE_MASK[8*p +: 8];
            end
        end
        if (wb_adr_i == BIDIO_OFS_WAKE_EN) begin
            rd_nxt[7:0] = wake_en_r;
        end
        if (wb_adr_i == BIDIO_OFS_POWER) begin
            rd_nxt[BIDIO_PWR_DOWN_BIT] = power_down_r;
            rd_nxt[BIDIO_PWR_WAKE_BIT] = wake_flag_r;
        end
        if (wb_adr_i == BIDIO_OFS_INFO) begin
            rd_nxt[7:0] = 8'(LINES);
            rd_nxt[BIDIO_INFO_ASW_BIT] = ASW_OPT;
            rd_nxt[BIDIO_INFO_RCO_BIT] = RCO_OPT;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= take;
            if (take) begin
                rdata_r <= wb_we_i ? 32'h00000000 : rd_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin outputs.
    logic [PW-1:0] drive_all;
    logic [PW-1:0] oe_all;
    logic [PW-1:0] pull_all;
    logic [LINES-1:0] pin_o_r;
    logic [LINES-1:0] pin_oe_r;
    logic [LINES-1:0] pullup_r;
    logic [7:0] asw_sel_r;
    logic [3:0] conv_sel_r;

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            drive_all[8*p +: 8] = port_drive[p];
            oe_all[8*p +: 8] = port_oe[p];
            pull_all[8*p +: 8] = port_pull[p];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o_r <= '0;
            pin_oe_r <= '0;
            pullup_r <= '0;
            asw_sel_r <= 8'h00;
            conv_sel_r <= 4'h0;
        end else begin
            pin_o_r <= drive_all[LINES-1:0];
            pin_oe_r <= oe_all[LINES-1:0];
            pullup_r <= pull_all[LINES-1:0];
            asw_sel_r <= SHARED_MASK[15:8];
            conv_sel_r <= SHARED_MASK[23:20];
        end
    end

    assign port_pin_o = pin_o_r;
    assign port_pin_oe_o = pin_oe_r;
    assign pullup_en_o = pullup_r;
    assign analog_switch_sel_o = asw_sel_r;
    assign converter_sel_o = conv_sel_r;
    assign power_down_o = power_down_r;
    assign wake_o = wake_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic first_r;
    logic [7:0] data_a;
    logic [7:0] dir_a;
    logic [7:0] view_a;
    logic rd_port_a;

    assign data_a = port_data[0];
    assign dir_a = port_dir[0];
    assign view_a = port_view[0];
    assign rd_port_a = take && !wb_we_i && wb_adr_i == BIDIO_OFS_A_DATA;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    dir_drive_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !first_r |=> port_pin_oe_o[7:0] == ~$past(dir_a))
        else $error("port A enable does not follow direction");
    input_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_port_a |=> ((wb_dat_o[7:0] ^ $past(pin_sync[7:0])) & $past(dir_a)) == 8'h00)
        else $error("input bit read differs from sampled pin");
    latch_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !(take && wb_we_i) |=> $stable(data_a))
        else $error("output latch changed without a write");
    output_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_port_a |=> ((wb_dat_o[7:0] ^ $past(data_a)) & ~$past(dir_a)) == 8'h00)
        else $error("output bit read differs from latch");
    reset_ones_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        first_r |-> data_a == 8'hFF && dir_a == 8'hFF && port_dir[2] == 8'hFF)
        else $error("port registers not all ones after reset");
    initial_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        first_r |=> port_pin_o[7:0] == 8'hFF)
        else $error("port A drive not high after reset");
    bit_rmw_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        bitop_wr && bit_tgt == 3'h0 |=> data_a[$past(bit_idx)] == $past(bit_val) &&
        ((data_a ^ $past(view_a)) & ~(8'h01 << $past(bit_idx))) == 8'h00)
        else $error("bit operation disturbed other bits");
    wake_up_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        power_down_r && (|fall_a) && !halt_wr |=> wake_o && !power_down_o)
        else $error("enabled falling edge did not wake");
    wake_select_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        power_down_r && !(|(prev_a_r & ~pin_sync[7:0] & wake_en_r)) |=> power_down_r)
        else $error("woke without an enabled falling edge");
    pullup_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !first_r |=> pullup_en_o[7:0] == ($past(dir_a) & PULLUP_OPT[7:0]))
        else $error("pull-up does not follow input direction");
    analog_sel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !first_r |-> analog_switch_sel_o == {8{ASW_OPT}})
        else $error("analog switch selection wrong");
    conv_sel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !first_r |-> converter_sel_o == {4{RCO_OPT}})
        else $error("converter selection wrong");
    shared_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !first_r |-> (port_pin_oe_o & SHARED_MASK[LINES-1:0]) == '0)
        else $error("shared pin driven by port logic");

    bitop_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) bitop_wr);
    wake_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) wake_evt ##1 wake_flag_r);
    multi_wake_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        power_down_r && $countones(fall_a) > 1);
    read_in_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_port_a && dir_a != 8'h00);

endmodule // bidio_top

/* bidio_ext_model.sv */
`timescale 1ns/10ps
module bidio_ext_model #(
    parameter int LINES = 24
) (
    input wire logic clock_i,
    input wire logic [LINES-1:0] drive_i,
    input wire logic [LINES-1:0] oe_i,
    input wire logic [LINES-1:0] pullup_i,
    input wire logic [LINES-1:0] ext_val_i,
    input wire logic [LINES-1:0] ext_en_i,
    output logic [LINES-1:0] level_o
);
    // A floating line without pull-up churns every cycle so a stale value is never read as data.
    logic [LINES-1:0] churn_r = '0;

    always @(posedge clock_i) begin
        churn_r <= ~churn_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // An external switch overpowers the pin driver, so a read that returns the pin shows up.
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            if (ext_en_i[i]) begin
                level_o[i] = ext_val_i[i];
            end else if (oe_i[i]) begin
                level_o[i] = drive_i[i];
            end else if (pullup_i[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = churn_r[i];
            end
        end
    end
endmodule // bidio_ext_model

/* bidio_tb.sv */
`timescale 1ns/10ps
module testbench;
    import bidio_pkg::*;
    localparam logic [23:0] PU = 24'h0000F0;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [23:0] pin_lvl, pin_o, pin_oe, pu_en, ext_val, ext_en;
    logic [7:0] asw_sel;
    logic [3:0] conv_sel;
    logic power_down_o, wake_o;
    logic [7:0] v, w, e;
    logic [31:0] exp_q[$];
    int miscompares = 0;
    int tests_run = 0;

    initial begin
        forever #20 clock_i = ~clock_i;
    end

    bidio_top #(.LINES(24), .PULLUP_OPT(PU), .ASW_OPT(1'b1), .RCO_OPT(1'b1)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pin_i(pin_lvl), .port_pin_o(pin_o),
        .port_pin_oe_o(pin_oe), .pullup_en_o(pu_en), .analog_switch_sel_o(asw_sel),
        .converter_sel_o(conv_sel), .power_down_o(power_down_o), .wake_o(wake_o));

    bidio_ext_model #(.LINES(24)) ext_u (
        .clock_i(clock_i), .drive_i(pin_o), .oe_i(pin_oe), .pullup_i(pu_en),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_lvl));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high at a rising edge, then release.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      input logic [3:0] sel);
        int n;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end else begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        wb(1'b1, adr, {24'h000000, d}, 4'hF);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(1'b0, adr, 32'h0, 4'hF);
    endtask

    task automatic settle();
        repeat (3) @(posedge clock_i);
    endtask

    task automatic wait_wake();
        int n;
        n = 0;
        while (wake_o !== 1'b1 && n < 12) begin
            @(posedge clock_i);
            n++;
        end
        chk({31'h0, wake_o}, 32'h1);
        if (wake_o !== 1'b1) begin
            tally_and_finish();
        end
    endtask

    // The read data is taken at the rising edge at which ack is sampled high.
    always @(posedge clock_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() > 0) begin
                chk(wb_dat_o, exp_q.pop_front());
            end else begin
                miscompares++;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, wb_dat_o, 32'h0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ext_val = 24'h000000;
        ext_en = 24'h000000;
        void'($urandom(28));
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(BIDIO_OFS_A_DIR, 32'hFF);
        rd(BIDIO_OFS_B_DIR, 32'hFF);
        rd(BIDIO_OFS_D_DIR, 32'hFF);
        rd(BIDIO_OFS_INFO, 32'h318);
        @(posedge clock_i);
        chk({8'h00, pin_oe}, 32'h0);
        chk({8'h00, pu_en}, {8'h00, PU});
        chk({20'h0, conv_sel, asw_sel}, 32'hFFF);
        $display("test reset done");
        ext_en <= 24'h0000FF;
        wr(BIDIO_OFS_A_DIR, 8'h00);
        settle();
        chk({24'h0, pin_o[7:0]}, 32'hFF);
        chk({24'h0, pin_oe[7:0]}, 32'hFF);
        rd(BIDIO_OFS_A_DATA, 32'hFF);
        v = 8'($urandom);
        wr(BIDIO_OFS_A_DATA, v);
        ext_en <= 24'h000000;
        repeat (8) @(posedge clock_i);
        chk({24'h0, pin_o[7:0]}, {24'h0, v});
        $display("test output latch done");
        w = 8'($urandom);
        ext_val <= {16'h0, w};
        ext_en <= 24'h0000FF;
        wr(BIDIO_OFS_A_DIR, 8'h0F);
        settle();
        rd(BIDIO_OFS_A_DATA, {24'h0, v[7:4], w[3:0]});
        w = ~w;
        ext_val <= {16'h0, w};
        settle();
        rd(BIDIO_OFS_A_DATA, {24'h0, v[7:4], w[3:0]});
        $display("test input sampling done");
        e = {v[7:4], w[3:0]};
        e[6] = ~v[6];
        wr(BIDIO_OFS_BITOP, {1'b0, 3'h0, ~v[6], 3'h6});
        ext_en <= 24'h000000;
        wr(BIDIO_OFS_A_DIR, 8'h00);
        settle();
        chk({24'h0, pin_o[7:0]}, {24'h0, e});
        rd(BIDIO_OFS_A_DATA, {24'h0, e});
        for (int t = 1; t < 6; t += 2) begin
            wr(BIDIO_OFS_A_DIR + 8'(t - 1) * BIDIO_DIR_STEP, 8'hFF);
            wr(BIDIO_OFS_BITOP, {1'b0, 3'(t), 1'b0, 3'h2});
            rd(BIDIO_OFS_A_DIR + 8'(t - 1) * BIDIO_DIR_STEP, 32'hFB);
        end
        $display("test bit operation done");
        wr(BIDIO_OFS_B_DIR, 8'h00);
        wr(BIDIO_OFS_B_DATA, 8'h55);
        wr(BIDIO_OFS_D_DIR, 8'h00);
        wr(BIDIO_OFS_D_DATA, 8'hA5);
        settle();
        chk({16'h0, pin_oe[23:8]}, 32'h0F00);
        chk({16'h0, pin_o[23:8]}, 32'h0500);
        rd(BIDIO_OFS_B_DATA, 32'h55);
        $display("test shared pins done");
        ext_val <= 24'h0000FF;
        ext_en <= 24'h0000FF;
        wr(BIDIO_OFS_A_DIR, 8'hFF);
        wr(BIDIO_OFS_WAKE_EN, 8'h0C);
        wr(BIDIO_OFS_POWER, 8'h01);
        settle();
        chk({31'h0, power_down_o}, 32'h1);
        ext_val <= 24'h0000FE;
        repeat (10) @(posedge clock_i);
        chk({31'h0, power_down_o}, 32'h1);
        ext_val <= 24'h0000F6;
        wait_wake();
        settle();
        chk({31'h0, power_down_o}, 32'h0);
        rd(BIDIO_OFS_POWER, 32'h2);
        wr(BIDIO_OFS_POWER, 8'h03);
        settle();
        rd(BIDIO_OFS_POWER, 32'h1);
        ext_val <= 24'h0000F2;
        wait_wake();
        $display("test wake done");
        rd(8'h28, 32'h0);
        rd(8'h01, 32'h0);
        wb(1'b1, BIDIO_OFS_D_DATA, 32'h11, 4'hE);
        rd(BIDIO_OFS_D_DATA, 32'hA5);
        $display("test refused access done");
        tally_and_finish();
    end
endmodule // testbench
